/* rtl/ufc_buf2.sv */
// small valid/ready buffer between filter and receive fifo
// assumes flush is a one-cycle pulse on the same clock
`timescale 1ns/1ns
module ufc_buf2 #(
    parameter int W = 8,
    parameter int DEPTH = 2
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic flush,
    ufc_buf_if.dst in,
    output logic outValid,
    output logic [W-1:0] outData,
    input wire logic outReady
);
    localparam int AW = $clog2(DEPTH);
    generate
        if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
            $error("buffer depth must be a power of two, at least 2");
        end
    endgenerate
    logic [W-1:0] mem_reg [DEPTH];
    logic [AW-1:0] wrPtr_reg;
    logic [AW-1:0] rdPtr_reg;
    logic [AW:0] cnt_reg;
    logic push;
    logic pop;
    assign in.ready = (cnt_reg != (AW + 1)'(DEPTH));
    assign outValid = (cnt_reg != '0);
    assign outData = mem_reg[rdPtr_reg];
    assign push = in.valid && in.ready;
    assign pop = outValid && outReady;
    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem_reg[wrPtr_reg] <= in.data;
        end
    end
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            wrPtr_reg <= '0;
            rdPtr_reg <= '0;
            cnt_reg <= '0;
        end else if (flush) begin
            wrPtr_reg <= '0;
            rdPtr_reg <= '0;
            cnt_reg <= '0;
        end else begin
            wrPtr_reg <= wrPtr_reg + AW'(push);
            rdPtr_reg <= rdPtr_reg + AW'(pop);
            cnt_reg <= cnt_reg + (AW + 1)'(push) - (AW + 1)'(pop);
        end
    end
    buf_bound_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        cnt_reg <= (AW + 1)'(DEPTH)) else $error("buffer count overrun");
    buf_hold_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        outValid && !outReady && !flush |=> outValid && $stable(outData))
        else $error("stalled word changed");
endmodule

/* rtl/ufc_buf_if.sv */
// push side of the receive data buffer
// assumes a single clock shared by both ends
`timescale 1ns/1ns
interface ufc_buf_if #(parameter int W = 8);
    logic valid;
    logic ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport dst (input valid, input data, output ready);
endinterface

/* rtl/ufc_cfg.svh */
// constants for the fifo trigger and flow control block
// assumes bit positions of the host-visible control words below
`ifndef UFC_CFG_SVH
`define UFC_CFG_SVH
// legacy tables, four 8-bit entries indexed by the 2-bit code
`define UFC_RX_LVLS 32'h1c18_1008
`define UFC_RESUME_LVLS 32'h170f_0700
`define UFC_TX_LVLS 32'h1e18_0810
`define UFC_LEGACY_DEPTH 8'h20
`define UFC_EXT_DEPTH 8'h80
`define UFC_OFF_DEPTH 8'h01
// fifo_control fields
`define UFC_FCR_EN 0
`define UFC_FCR_TX_LO 4
`define UFC_FCR_RX_LO 6
// enhanced_features fields
`define UFC_EFR_RXSW 1
`define UFC_EFR_RXDBL 0
`define UFC_EFR_TXSW 3
`define UFC_EFR_TXDBL 2
`define UFC_EFR_TXLVL 4
`define UFC_EFR_RTS 6
`define UFC_EFR_CTS 7
// irq_mask, aux control, line format fields
`define UFC_IER_RX 0
`define UFC_IER_XOFF 5
`define UFC_IER_CTS 7
`define UFC_AUX_REMAP 2
`define UFC_LCR_STOP 2
`define UFC_LCR_PAR 3
// time-out length in character times
`define UFC_TIMEOUT_CHARS 3'h4
`endif

/* rtl/ufc_flow_ctrl.sv */
// fifo trigger levels, fifo flush, hardware and xon/xoff flow control
// assumes receiver, transmitter and fifos on clk_sys; pins asynchronous
// Functional notes
// RULE1: all thresholds zero: legacy levels, 32 deep
// RULE2: fifo_control bit 0 enables both fifos
// RULE3: tx level active only after enhanced bit 4
// RULE4: legacy tables for rx, resume, tx levels
// RULE5: receive time-out interrupt for sub-trigger data
// RULE6: any threshold nonzero: programmable 1..128 levels
// RULE7: flush fifos on enable or mode change
// RULE8: enhanced bits 6 and 7 enable auto rts/cts
// RULE9: cts rise flags, holds tx until low
// RULE10: aux bit 2 moves flow to dsr/dtr
// RULE11: rts stops above trigger, resumes below
// RULE12: receive keeps filling while rts is off
// RULE13: extended mode uses stop and resume levels
// RULE14: software keeps stop above resume, unchecked
// RULE15: software loads levels before enabling flow
// RULE16: xoff match halts tx after current char
// RULE17: xoff match sets status, raises interrupt
// RULE18: xon match resumes tx, clears status
// RULE19: reset clears the four flow characters
// RULE20: double mode matches two consecutive chars
// RULE21: matched flow chars never enter fifo
// RULE22: send xoff above level, xon below resume
// RULE23: time-out after four idle char times
// RULE24: software selects threshold bank before access
// RULE25: match width follows programmed word length
// RULE26: low enhanced bits select software flow modes
`timescale 1ns/1ns
`include "ufc_cfg.svh"
module ufc_flow_ctrl
    import ufc_pkg::*;
#(
    parameter int BUF_DEPTH = 2
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic [7:0] fifoControl,
    input wire logic [7:0] enhancedFeatures,
    input wire logic [7:0] irqMask,
    input wire logic [7:0] auxFeatureControlOne,
    input wire logic [7:0] lineFormatControl,
    input wire logic [7:0] txIrqThreshold,
    input wire logic [7:0] rxIrqThreshold,
    input wire logic [7:0] flowStopLevel,
    input wire logic [7:0] flowResumeLevel,
    input wire logic charWrEn,
    input wire logic [1:0] charWrSel,
    input wire logic [7:0] charWrData,
    input wire logic [7:0] rxCount,
    input wire logic [7:0] txCount,
    input wire logic hostRead,
    input wire logic bitTick,
    input wire logic stopMid,
    input wire logic rxInValid,
    input wire logic [7:0] rxInData,
    output logic rxInReady,
    output logic fifoWrValid,
    output logic [7:0] fifoWrData,
    input wire logic fifoWrReady,
    output logic sendValid,
    output logic [7:0] sendData,
    input wire logic sendReady,
    input wire logic ctsN,
    input wire logic dsrN,
    input wire logic modemRts,
    input wire logic modemDtr,
    output logic rtsN,
    output logic dtrN,
    input wire logic statusClear,
    output logic txHold,
    output logic fifoFlush,
    output logic [7:0] fifoDepth,
    output logic rxTrigIrq,
    output logic txTrigIrq,
    output logic rxTimeout,
    output logic xoffFlag,
    output logic ctsFlag,
    output logic rxIntr
);
    generate
        if (BUF_DEPTH != 2) begin : g_chk
            $error("receive buffer is sized for two entries");
        end
    endgenerate

    function automatic logic [7:0] pick(input logic [31:0] tbl, input logic [1:0] code);
        pick = tbl[{code, 3'b000} +: 8];
    endfunction

    function automatic logic [7:0] maskWl(input logic [7:0] c, input logic [1:0] wl);
        maskWl = c & (8'hff >> (2'h3 - wl));
    endfunction

    ufc_buf_if #(.W(8)) bufIn ();

    logic extMode;
    logic fifosOn;
    logic [7:0] rxTrig;
    logic [7:0] txTrig;
    logic [7:0] stopLvl;
    logic [7:0] resumeLvl;
    logic fifosOn_reg;
    logic extMode_reg;
    logic flush_reg;
    logic [7:0] depth_reg;
    logic [7:0] xon1_reg;
    logic [7:0] xon2_reg;
    logic [7:0] xoff1_reg;
    logic [7:0] xoff2_reg;
    logic ctsMeta_reg;
    logic ctsSync_reg;
    logic dsrMeta_reg;
    logic dsrSync_reg;
    logic flowInPrev_reg;
    logic flowIn;
    logic autoRts;
    logic autoCts;
    logic remap;
    logic flowOff_reg;
    logic flowOffPrev_reg;
    logic xoffHold_reg;
    logic xoffFlag_reg;
    logic ctsFlag_reg;
    logic rxTrig_reg;
    logic txTrig_reg;
    logic [5:0] toCnt_reg;
    logic toFlag_reg;
    logic [5:0] toLimit;
    logic pend_reg;
    logic [7:0] pendData_reg;
    logic pendOn_reg;
    ufc_send_e send_reg;
    logic sendOff_reg;
    logic [7:0] sendData_reg;
    logic [7:0] rc;
    logic swRx;
    logic dbl;
    logic take;
    logic m1Off;
    logic m1On;
    logic m2Off;
    logic m2On;
    logic xoffHit;
    logic xonHit;
    logic dropChar;
    logic emitPend;

    // RULE1 legacy select
    assign extMode = (txIrqThreshold | rxIrqThreshold | flowStopLevel | flowResumeLevel) != 8'h00;
    // RULE2 fifo enable
    assign fifosOn = fifoControl[`UFC_FCR_EN];

    // RULE4 legacy tables
    // RULE6 extended thresholds
    // RULE13 extended flow levels
    always_comb begin
        if (extMode) begin
            rxTrig = rxIrqThreshold;
            txTrig = txIrqThreshold;
            stopLvl = flowStopLevel;
            resumeLvl = flowResumeLevel;
        end else begin
            rxTrig = pick(`UFC_RX_LVLS, fifoControl[`UFC_FCR_RX_LO +: 2]);
            stopLvl = rxTrig;
            resumeLvl = pick(`UFC_RESUME_LVLS, fifoControl[`UFC_FCR_RX_LO +: 2]);
            // RULE3 tx level gated
            if (enhancedFeatures[`UFC_EFR_TXLVL]) begin
                txTrig = pick(`UFC_TX_LVLS, fifoControl[`UFC_FCR_TX_LO +: 2]);
            end else begin
                txTrig = pick(`UFC_TX_LVLS, 2'b00);
            end
        end
    end

    // RULE7 flush on change
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            fifosOn_reg <= 1'b0;
            extMode_reg <= 1'b0;
            flush_reg <= 1'b0;
            depth_reg <= `UFC_OFF_DEPTH;
        end else begin
            fifosOn_reg <= fifosOn;
            extMode_reg <= extMode;
            flush_reg <= (fifosOn != fifosOn_reg) || (extMode != extMode_reg);
            // RULE2 fifo depth
            depth_reg <= !fifosOn ? `UFC_OFF_DEPTH : extMode ? `UFC_EXT_DEPTH : `UFC_LEGACY_DEPTH;
        end
    end
    assign fifoFlush = flush_reg;
    assign fifoDepth = depth_reg;

    // RULE19 flow characters reset
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            xon1_reg <= 8'h00;
            xon2_reg <= 8'h00;
            xoff1_reg <= 8'h00;
            xoff2_reg <= 8'h00;
        end else if (charWrEn) begin
            case (charWrSel)
                2'h0: xon1_reg <= charWrData;
                2'h1: xon2_reg <= charWrData;
                2'h2: xoff1_reg <= charWrData;
                default: xoff2_reg <= charWrData;
            endcase
        end
    end

    // modem pins are asynchronous
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            ctsMeta_reg <= 1'b0;
            ctsSync_reg <= 1'b0;
            dsrMeta_reg <= 1'b0;
            dsrSync_reg <= 1'b0;
            flowInPrev_reg <= 1'b0;
        end else begin
            ctsMeta_reg <= ctsN;
            ctsSync_reg <= ctsMeta_reg;
            dsrMeta_reg <= dsrN;
            dsrSync_reg <= dsrMeta_reg;
            flowInPrev_reg <= flowIn;
        end
    end

    // RULE8 auto enables
    assign autoRts = enhancedFeatures[`UFC_EFR_RTS];
    assign autoCts = enhancedFeatures[`UFC_EFR_CTS];
    // RULE10 dsr/dtr remap
    assign remap = auxFeatureControlOne[`UFC_AUX_REMAP];
    assign flowIn = remap ? dsrSync_reg : ctsSync_reg;

    // RULE11 stop/resume hysteresis
    // RULE22 same levels for xoff/xon
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            flowOff_reg <= 1'b0;
            flowOffPrev_reg <= 1'b0;
        end else begin
            flowOffPrev_reg <= flowOff_reg;
            if (flush_reg) begin
                flowOff_reg <= 1'b0;
            end else if (rxCount >= stopLvl) begin
                flowOff_reg <= 1'b1;
            end else if (rxCount <= resumeLvl) begin
                flowOff_reg <= 1'b0;
            end
        end
    end
    // RULE10 pin steering
    assign rtsN = (!remap && autoRts && flowOff_reg) ? 1'b1 : !modemRts;
    assign dtrN = (remap && autoRts && flowOff_reg) ? 1'b1 : !modemDtr;

    // RULE5 trigger interrupts
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            rxTrig_reg <= 1'b0;
            txTrig_reg <= 1'b0;
        end else begin
            rxTrig_reg <= fifosOn && rxCount >= rxTrig && rxCount != 8'h00;
            txTrig_reg <= fifosOn && txCount <= txTrig;
        end
    end
    assign rxTrigIrq = rxTrig_reg;
    assign txTrigIrq = txTrig_reg;

    // RULE23 four char time-out
    // bit count: start, data, parity, stop; 1.5 stop bits counted as 2
    assign toLimit = 6'(`UFC_TIMEOUT_CHARS) * (6'd7 + 6'(lineFormatControl[1:0])
        + 6'(lineFormatControl[`UFC_LCR_PAR]) + 6'(lineFormatControl[`UFC_LCR_STOP]));
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            toCnt_reg <= 6'h00;
            toFlag_reg <= 1'b0;
        end else if (stopMid || hostRead || rxCount == 8'h00 || flush_reg) begin
            toCnt_reg <= 6'h00;
            toFlag_reg <= 1'b0;
        end else if (bitTick && !toFlag_reg) begin
            if (toCnt_reg + 6'h01 >= toLimit) begin
                toFlag_reg <= 1'b1;
            end
            toCnt_reg <= toCnt_reg + 6'h01;
        end
    end
    assign rxTimeout = toFlag_reg;

    // RULE26 software flow modes
    assign swRx = enhancedFeatures[`UFC_EFR_RXSW];
    assign dbl = enhancedFeatures[`UFC_EFR_RXDBL];
    // RULE25 word-length compare
    assign rc = maskWl(rxInData, lineFormatControl[1:0]);
    assign m1Off = rc == maskWl(xoff1_reg, lineFormatControl[1:0]);
    assign m1On = rc == maskWl(xon1_reg, lineFormatControl[1:0]);
    assign m2Off = rc == maskWl(xoff2_reg, lineFormatControl[1:0]);
    assign m2On = rc == maskWl(xon2_reg, lineFormatControl[1:0]);

    // RULE20 two-char sequence
    assign emitPend = pend_reg && rxInValid
        && !(pendOn_reg ? m2On : m2Off);
    assign xoffHit = swRx && rxInValid && (dbl ? (pend_reg && !pendOn_reg && m2Off) : m1Off);
    assign xonHit = swRx && rxInValid && (dbl ? (pend_reg && pendOn_reg && m2On) : m1On);
    // RULE21 matched chars dropped
    assign dropChar = xoffHit || xonHit
        || (swRx && dbl && !pend_reg && (m1Off || m1On));
    // RULE12 only buffer space or emitting the pending char stalls receive
    assign rxInReady = !emitPend && bufIn.ready;
    assign take = rxInValid && rxInReady;

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            pend_reg <= 1'b0;
            pendOn_reg <= 1'b0;
            pendData_reg <= 8'h00;
        end else if (flush_reg || !swRx || !dbl) begin
            pend_reg <= 1'b0;
        end else if (emitPend && bufIn.ready) begin
            pend_reg <= 1'b0;
        end else if (take) begin
            pend_reg <= !pend_reg && (m1Off || m1On);
            pendOn_reg <= m1On;
            pendData_reg <= rxInData;
        end
    end

    assign bufIn.valid = emitPend || (take && !dropChar);
    assign bufIn.data = emitPend ? pendData_reg : rxInData;

    ufc_buf2 #(.W(8), .DEPTH(BUF_DEPTH)) u_buf (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .flush(flush_reg),
        .in(bufIn),
        .outValid(fifoWrValid),
        .outData(fifoWrData),
        .outReady(fifoWrReady)
    );

    // RULE16 xoff suspends
    // RULE18 xon resumes
    // RULE17 xoff status, set wins
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            xoffHold_reg <= 1'b0;
            xoffFlag_reg <= 1'b0;
        end else begin
            if (xoffHit) begin
                xoffHold_reg <= 1'b1;
            end else if (xonHit || !swRx) begin
                xoffHold_reg <= 1'b0;
            end
            if (xoffHit && irqMask[`UFC_IER_XOFF]) begin
                xoffFlag_reg <= 1'b1;
            end else if (xonHit || statusClear) begin
                xoffFlag_reg <= 1'b0;
            end
        end
    end

    // RULE9 cts rise flag, set wins
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            ctsFlag_reg <= 1'b0;
        end else if (autoCts && flowIn && !flowInPrev_reg && irqMask[`UFC_IER_CTS]) begin
            ctsFlag_reg <= 1'b1;
        end else if (statusClear) begin
            ctsFlag_reg <= 1'b0;
        end
    end
    assign xoffFlag = xoffFlag_reg;
    assign ctsFlag = ctsFlag_reg;
    // transmitter samples hold only between characters
    assign txHold = (autoCts && flowIn) || xoffHold_reg;
    assign rxIntr = irqMask[`UFC_IER_RX] && (rxTrig_reg || toFlag_reg || xoffFlag_reg);

    // RULE22 xoff/xon insertion
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            send_reg <= UFC_IDLE;
            sendOff_reg <= 1'b0;
            sendData_reg <= 8'h00;
        end else begin
            case (send_reg)
                UFC_IDLE: begin
                    if (enhancedFeatures[`UFC_EFR_TXSW] && flowOff_reg != flowOffPrev_reg) begin
                        sendOff_reg <= flowOff_reg;
                        sendData_reg <= flowOff_reg ? xoff1_reg : xon1_reg;
                        send_reg <= UFC_SEND1;
                    end
                end
                UFC_SEND1: begin
                    if (sendReady) begin
                        sendData_reg <= sendOff_reg ? xoff2_reg : xon2_reg;
                        send_reg <= enhancedFeatures[`UFC_EFR_TXDBL] ? UFC_SEND2 : UFC_IDLE;
                    end
                end
                UFC_SEND2: begin
                    if (sendReady) begin
                        send_reg <= UFC_IDLE;
                    end
                end
                default: send_reg <= UFC_IDLE;
            endcase
        end
    end
    assign sendValid = send_reg != UFC_IDLE;
    assign sendData = sendData_reg;

    legacy_depth_a: assert property (@(posedge clk_sys) disable iff (!resetn) // RULE1
        fifosOn && !extMode |=> depth_reg == `UFC_LEGACY_DEPTH)
        else $error("legacy depth wrong");
    off_depth_a: assert property (@(posedge clk_sys) disable iff (!resetn) // RULE2
        !fifosOn |=> depth_reg == `UFC_OFF_DEPTH)
        else $error("disabled depth wrong");
    mode_flush_a: assert property (@(posedge clk_sys) disable iff (!resetn) // RULE7
        $changed(extMode) |-> ##1 fifoFlush)
        else $error("mode change did not flush");
    cts_flag_a: assert property (@(posedge clk_sys) disable iff (!resetn) // RULE9
        autoCts && irqMask[7] && $rose(flowIn) |=> ctsFlag)
        else $error("cts rise not flagged");
    rts_off_a: assert property (@(posedge clk_sys) disable iff (!resetn) // RULE11
        autoRts && !remap && !flush_reg && rxCount >= stopLvl |=> rtsN)
        else $error("rts not stopped at level");
    xoff_hold_a: assert property (@(posedge clk_sys) disable iff (!resetn) // RULE16
        xoffHit |=> txHold)
        else $error("xoff did not hold tx");
    xon_clear_a: assert property (@(posedge clk_sys) disable iff (!resetn) // RULE18
        xonHit && !xoffHit |=> !xoffFlag_reg && !xoffHold_reg)
        else $error("xon did not resume");
    drop_match_a: assert property (@(posedge clk_sys) disable iff (!resetn) // RULE21
        take && xoffHit && !emitPend |-> !bufIn.valid)
        else $error("flow char stored");
    timeout_a: assert property (@(posedge clk_sys) disable iff (!resetn) // RULE23
        $rose(toFlag_reg) |-> $past(rxCount) != 8'h00 && $past(toCnt_reg) + 6'h01 >= toLimit)
        else $error("early time-out");
    send_xoff_a: assert property (@(posedge clk_sys) disable iff (!resetn) // RULE22
        $rose(sendValid) && sendOff_reg |-> sendData == xoff1_reg)
        else $error("xoff not sent first");

    xoff_c: cover property (@(posedge clk_sys) disable iff (!resetn) xoffHit ##[1:50] xonHit);
    flush_c: cover property (@(posedge clk_sys) disable iff (!resetn) fifoFlush);
    dbl_send_c: cover property (@(posedge clk_sys) disable iff (!resetn) send_reg == UFC_SEND2);
    to_c: cover property (@(posedge clk_sys) disable iff (!resetn) $rose(rxTimeout));
endmodule

/* rtl/ufc_pkg.sv */
// types shared by the flow control block
// assumes ufc_cfg.svh holds the numeric constants
package ufc_pkg;
    typedef logic [7:0] ufc_char_t;
    typedef enum logic [1:0] {UFC_IDLE, UFC_SEND1, UFC_SEND2} ufc_send_e;
endpackage

/* tb/testbench.sv */
// self-checking bench for the fifo trigger and flow control block
// assumes the remote model in ufc_remote.sv; no register bus, levels are ports
`timescale 1ns/1ns
`include "ufc_cfg.svh"
module testbench;
    logic clk_sys = 1'b0;
    logic resetn = 1'b0;
    logic [7:0] fifoControl, enhancedFeatures, irqMask, auxFeatureControlOne, lineFormatControl;
    logic [7:0] txIrqThreshold, rxIrqThreshold, flowStopLevel, flowResumeLevel;
    logic charWrEn, hostRead, bitTick, stopMid, fifoWrReady, modemRts, modemDtr, statusClear, ok;
    logic [1:0] charWrSel;
    logic [7:0] charWrData, rxCount, txCount, rxInData, fifoWrData, sendData, fifoDepth;
    logic rxInValid, rxInReady, fifoWrValid, sendValid, sendReady, ctsN, dsrN, rtsN, dtrN;
    logic txHold, fifoFlush, rxTrigIrq, txTrigIrq, rxTimeout, xoffFlag, ctsFlag, rxIntr;
    int miscompares = 0;
    int comparisons = 0;
    int lvl [4] = '{8, 16, 24, 28};
    always #50 clk_sys = ~clk_sys;
    ufc_flow_ctrl dut_u (.clk_sys(clk_sys), .resetn(resetn), .fifoControl(fifoControl),
        .enhancedFeatures(enhancedFeatures), .irqMask(irqMask),
        .auxFeatureControlOne(auxFeatureControlOne), .lineFormatControl(lineFormatControl),
        .txIrqThreshold(txIrqThreshold), .rxIrqThreshold(rxIrqThreshold),
        .flowStopLevel(flowStopLevel), .flowResumeLevel(flowResumeLevel), .charWrEn(charWrEn),
        .charWrSel(charWrSel), .charWrData(charWrData), .rxCount(rxCount), .txCount(txCount),
        .hostRead(hostRead), .bitTick(bitTick), .stopMid(stopMid), .rxInValid(rxInValid),
        .rxInData(rxInData), .rxInReady(rxInReady), .fifoWrValid(fifoWrValid),
        .fifoWrData(fifoWrData), .fifoWrReady(fifoWrReady), .sendValid(sendValid),
        .sendData(sendData), .sendReady(sendReady), .ctsN(ctsN), .dsrN(dsrN),
        .modemRts(modemRts), .modemDtr(modemDtr), .rtsN(rtsN), .dtrN(dtrN),
        .statusClear(statusClear), .txHold(txHold), .fifoFlush(fifoFlush),
        .fifoDepth(fifoDepth), .rxTrigIrq(rxTrigIrq), .txTrigIrq(txTrigIrq),
        .rxTimeout(rxTimeout), .xoffFlag(xoffFlag), .ctsFlag(ctsFlag), .rxIntr(rxIntr));
    ufc_remote rem_u (.clk_sys(clk_sys), .rxInReady(rxInReady), .sendValid(sendValid),
        .sendData(sendData), .sendReady(sendReady), .rxInValid(rxInValid),
        .rxInData(rxInData), .ctsN(ctsN), .dsrN(dsrN));
    task stop_test();
        if (miscompares == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task chk(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task cyc(input int n);
        repeat (n) @(negedge clk_sys);
    endtask
    // bounded wait; running out counts as a mismatch and ends the run
    task automatic wait_v(ref logic s, input logic v);
        for (int i = 0; i < 40 && s !== v; i++) cyc(1);
        chk(s, v);
        if (s !== v) stop_test();
    endtask
    task automatic wait_sent(input logic [7:0] c);
        for (int i = 0; i < 40 && rem_u.lastSent !== c; i++) cyc(1);
        chk(rem_u.lastSent, c);
        if (rem_u.lastSent !== c) stop_test();
    endtask
    task wrc(input logic [1:0] sel, input logic [7:0] d);
        @(negedge clk_sys);
        charWrEn = 1'b1;
        charWrSel = sel;
        charWrData = d;
        cyc(1);
        charWrEn = 1'b0;
    endtask
    task rx(input logic [7:0] c);
        rem_u.send_char(c, ok);
        chk(ok, 1'b1);
        if (ok !== 1'b1) stop_test();
    endtask
    initial begin
        {fifoControl, enhancedFeatures, irqMask, auxFeatureControlOne, lineFormatControl} = '0;
        {txIrqThreshold, rxIrqThreshold, flowStopLevel, flowResumeLevel, rxCount, txCount} = '0;
        {charWrEn, charWrSel, charWrData, hostRead, bitTick, stopMid, statusClear} = '0;
        {fifoWrReady, modemRts, modemDtr} = 3'b111;
        cyc(2);
        resetn = 1'b1;
        chk(fifoDepth, 8'h01); chk(rtsN, 1'b0); chk(xoffFlag, 1'b0);
        fifoControl = 8'h01;
        wait_v(fifoFlush, 1'b1);
        cyc(1);
        chk(fifoDepth, 8'h20);
        irqMask = 8'h01;
        for (int c = 0; c < 4; c++) begin
            fifoControl = {c[1:0], c[1:0], 4'h1};
            {rxCount, txCount} = {8'(lvl[c] - 1), 8'h11};
            cyc(3);
            chk(rxTrigIrq, 1'b0);
            chk(txTrigIrq, 1'b0);
            rxCount = 8'(lvl[c]);
            cyc(3);
            chk(rxTrigIrq, 1'b1); chk(rxIntr, 1'b1);
        end
        // levels set before flow on, stop above resume
        {rxIrqThreshold, flowStopLevel, flowResumeLevel, rxCount} = {8'h05, 8'h0a, 8'h04, 8'h04};
        wait_v(fifoFlush, 1'b1);
        cyc(3);
        chk(fifoDepth, 8'h80); chk(rxTrigIrq, 1'b0);
        enhancedFeatures = 8'h40;
        rxCount = 8'h0a;
        cyc(3);
        chk(rtsN, 1'b1);
        rxCount = 8'h05;
        cyc(3);
        chk(rtsN, 1'b1); chk(rxTrigIrq, 1'b1);
        rxCount = 8'h04;
        cyc(3);
        chk(rtsN, 1'b0);
        auxFeatureControlOne = 8'h04;
        rxCount = 8'h0a;
        cyc(3);
        chk(dtrN, 1'b1); chk(rtsN, 1'b0);
        {auxFeatureControlOne, rxCount} = '0;
        {enhancedFeatures, irqMask} = {8'hc0, 8'ha1};
        rem_u.set_stop(1'b1);
        wait_v(ctsFlag, 1'b1);
        chk(txHold, 1'b1);
        rem_u.set_stop(1'b0);
        wait_v(txHold, 1'b0);
        statusClear = 1'b1;
        cyc(1);
        statusClear = 1'b0;
        cyc(2);
        chk(ctsFlag, 1'b0);
        wrc(2'h0, 8'h11); wrc(2'h1, 8'h12); wrc(2'h2, 8'h13); wrc(2'h3, 8'h14);
        enhancedFeatures = 8'h02;
        rx(8'h13);
        chk(fifoWrValid, 1'b0);
        wait_v(xoffFlag, 1'b1);
        chk(txHold, 1'b1); chk(rxIntr, 1'b1);
        rx(8'h41);
        chk(fifoWrValid, 1'b1); chk(fifoWrData, 8'h41);
        rx(8'h11);
        wait_v(xoffFlag, 1'b0);
        chk(txHold, 1'b0);
        enhancedFeatures = 8'h03;
        rx(8'h13);
        rx(8'h14);
        wait_v(xoffFlag, 1'b1);
        rx(8'h11);
        rx(8'h12);
        wait_v(xoffFlag, 1'b0);
        // receiver stalls, two words stand
        {enhancedFeatures, fifoWrReady} = '0;
        rx(8'h21);
        rx(8'h22);
        #10 chk(rxInReady, 1'b0);
        cyc(1);
        fifoWrReady = 1'b1;
        chk(fifoWrData, 8'h21);
        cyc(1);
        chk(fifoWrValid, 1'b1); chk(fifoWrData, 8'h22);
        rem_u.slow = 1'b1;
        enhancedFeatures = 8'h08;
        rxCount = 8'h0a;
        wait_sent(8'h13);
        rxCount = 8'h03;
        wait_sent(8'h11);
        {enhancedFeatures, rxCount, bitTick} = {8'h00, 8'h01, 1'b1};
        cyc(26);
        chk(rxTimeout, 1'b0);
        cyc(4);
        chk(rxTimeout, 1'b1); chk(rxIntr, 1'b1);
        stopMid = 1'b1;
        cyc(1);
        {stopMid, bitTick} = '0;
        cyc(1);
        chk(rxTimeout, 1'b0);
        fifoControl = 8'h00;
        wait_v(fifoFlush, 1'b1);
        cyc(1);
        chk(fifoDepth, 8'h01);
        stop_test();
    end
endmodule

/* tb/ufc_remote.sv */
// remote uart model: sends received chars, takes flow chars, drives cts/dsr
// assumes the flow block on clk_sys with inputs changed at the falling edge
`timescale 1ns/1ns
module ufc_remote (
    input wire logic clk_sys,
    input wire logic rxInReady,
    input wire logic sendValid,
    input wire logic [7:0] sendData,
    output logic sendReady,
    output logic rxInValid,
    output logic [7:0] rxInData,
    output logic ctsN,
    output logic dsrN
);
    logic slow = 1'b0;
    logic [7:0] lastSent = 8'h00;
    initial begin
        {rxInValid, ctsN, dsrN, sendReady} = '0;
        rxInData = 8'h00;
    end
    // slow mode accepts flow chars on alternate cycles only
    always @(posedge clk_sys) begin
        if (sendValid && sendReady) begin
            lastSent <= sendData;
        end
        sendReady <= slow ? !sendReady : 1'b1;
    end
    // both pins carry the same stop request, remap picks one
    task automatic set_stop(input logic s);
        ctsN = s;
        dsrN = s;
    endtask
    // held until taken or 20 cycles pass; released line shows inverse
    task automatic send_char(input logic [7:0] c, output logic ok);
        int i;
        @(negedge clk_sys);
        rxInValid = 1'b1;
        rxInData = c;
        ok = 1'b0;
        for (i = 0; i < 20 && !ok; i++) begin
            #10;
            ok = rxInReady;
            @(negedge clk_sys);
        end
        rxInValid = 1'b0;
        rxInData = ~c;
    endtask
endmodule
